// [clock_ratio_pkg.sv]
// Purpose: Shared constants for the core clock ratio and reset release block
// Assumes: One reference clock of 50 MHz drives every register
// Notes:   Offsets are byte addresses on a 32-bit classic Wishbone slave
package clock_ratio_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned REF_PERIOD_NS           = 20;
    localparam int unsigned CORE_RESET_BASE_CYCLES  = 4096;
    localparam int unsigned CORE_RESET_EXTRA_CYCLES = 2;
    localparam int unsigned CORE_RESET_CYCLES       =
        CORE_RESET_BASE_CYCLES + CORE_RESET_EXTRA_CYCLES;
    localparam int unsigned CORE_RESET_CNT_W        = 13;

    ////////////////////////////////////////////////////////////////////////
    // Field widths
    localparam int unsigned MULT_W    = 6;
    localparam int unsigned DIVCODE_W = 2;
    localparam int unsigned SDR_W     = 3;
    localparam int unsigned ADR_W     = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] RATIO_OFFSET  = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in power_mgmt_control
    localparam int unsigned CTRL_MULT_LSB  = 0;
    localparam int unsigned CTRL_DIV_LSB   = 8;
    localparam int unsigned CTRL_HALVE_BIT = 12;
    localparam int unsigned CTRL_SDR_LSB   = 16;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and encodings
    localparam logic [1:0] DIVCODE_RESET = 2'h0;
    localparam logic       HALVE_RESET   = 1'b0;
    localparam logic [2:0] SDR_RESET     = 3'h2;
    localparam logic [4:0] POST_DIV_MIN  = 5'h02;
    localparam logic [5:0] STRAP_MULT_0  = 6'h08;
    localparam logic [5:0] STRAP_MULT_1  = 6'h20;
    localparam logic [5:0] STRAP_MULT_2  = 6'h10;
    localparam logic [5:0] STRAP_MULT_3  = 6'h08;

endpackage : clock_ratio_pkg

// [ratio_decode.sv]
// Purpose: Decode ratio pins to a multiplier and divider code to a divisor
// Assumes: Purely combinational, used inside the clock ratio controller
// Notes:   Strap table values are plain defaults
`timescale 1ns/1ps
module ratio_decode #(
    parameter logic [5:0] MULT_0 = clock_ratio_pkg::STRAP_MULT_0,
    parameter logic [5:0] MULT_1 = clock_ratio_pkg::STRAP_MULT_1,
    parameter logic [5:0] MULT_2 = clock_ratio_pkg::STRAP_MULT_2,
    parameter logic [5:0] MULT_3 = clock_ratio_pkg::STRAP_MULT_3
) (
    input  wire logic [1:0] ratio_select_pins_i,
    input  wire logic [1:0] div_code_i,
    output logic      [5:0] strap_mult_o,
    output logic      [4:0] post_divider_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin strap to multiplier
    always_comb begin
        case (ratio_select_pins_i)
            2'h0:    strap_mult_o = MULT_0;
            2'h1:    strap_mult_o = MULT_1;
            2'h2:    strap_mult_o = MULT_2;
            default: strap_mult_o = MULT_3;
        endcase
    end

    // Divider code 0..3 gives 2, 4, 8, 16
    assign post_divider_o = clock_ratio_pkg::POST_DIV_MIN << div_code_i;

endmodule : ratio_decode

// [core_reset_release.sv]
// Purpose: Hold core reset a fixed count of reference cycles after reset
// Assumes: rst_i is synchronous to the reference clock
// Notes:   Counter restarts on every reassertion of rst_i
`timescale 1ns/1ps
module core_reset_release #(
    parameter int unsigned RELEASE_CYCLES = clock_ratio_pkg::CORE_RESET_CYCLES,
    parameter int unsigned CNT_W          = clock_ratio_pkg::CORE_RESET_CNT_W
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      core_reset_o
);

    typedef enum logic [2:0] {
        IN_RESET = 3'b001,
        COUNTING = 3'b010,
        RUNNING  = 3'b100
    } rel_state_e;

    rel_state_e             state;
    logic       [CNT_W-1:0] count;

    ////////////////////////////////////////////////////////////////////////
    // Release sequencer; core reset falls on the terminal count edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state        <= IN_RESET;
            count        <= '0;
            core_reset_o <= 1'b1;
        end else begin
            case (state)
                IN_RESET: begin
                    state <= COUNTING;
                    count <= CNT_W'(1);
                end
                COUNTING: begin
                    count <= count + CNT_W'(1);
                    if (count == CNT_W'(RELEASE_CYCLES - 1)) begin
                        state        <= RUNNING;
                        core_reset_o <= 1'b0;
                    end
                end
                default: state <= RUNNING;
            endcase
        end
    end

    property p_release_count;
        @(posedge clk_i) disable iff (rst_i)
        $fell(core_reset_o) |-> $past(count) == CNT_W'(RELEASE_CYCLES - 1);
    endproperty
    a_release_count: assert property (p_release_count)
        else $error("core reset released at wrong count");

    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> core_reset_o && count == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("release counter did not restart");

    property p_no_late_release;
        @(posedge clk_i) disable iff (rst_i)
        core_reset_o |-> count < CNT_W'(RELEASE_CYCLES);
    endproperty
    a_no_late_release: assert property (p_no_late_release)
        else $error("core reset held beyond release count");

endmodule : core_reset_release

// [pll_clock_ratio_ctrl.sv]
// Purpose: Core clock ratio control and core reset release
// Assumes: clk_i is the reference clock; classic Wishbone slave, 1 wait
// Notes:   Ratios are reported as integer numerator and divisors of the
//          reference frequency; the analog loop itself is outside
`timescale 1ns/1ps
module pll_clock_ratio_ctrl #(
    parameter int unsigned RELEASE_CYCLES = clock_ratio_pkg::CORE_RESET_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic [1:0]  ratio_select_pins_i,
    output logic             core_reset_o,
    output logic      [5:0]  pll_multiplier_o,
    output logic      [4:0]  post_divider_o,
    output logic             input_halve_enable_o,
    output logic      [2:0]  sdram_clock_ratio_o,
    output logic      [6:0]  vco_mult_o,
    output logic      [5:0]  core_div_o,
    output logic      [6:0]  periph_div_o,
    output logic      [7:0]  sdram_div_o
);

    logic       [1:0]  div_code;
    logic       [1:0]  strap_pins;
    logic       [5:0]  strap_mult;
    logic       [4:0]  post_div_value;
    logic              req;
    logic              wr_ctrl;
    logic       [31:0] ctrl_word;
    logic       [31:0] next_dat;
    logic       [6:0]  next_vco;
    logic       [5:0]  next_core_div;

    ////////////////////////////////////////////////////////////////////////
    // Decoders and reset release
    ratio_decode u_decode (
        .ratio_select_pins_i (ratio_select_pins_i),
        .div_code_i          (div_code),
        .strap_mult_o        (strap_mult),
        .post_divider_o      (post_div_value)
    );

    core_reset_release #(
        .RELEASE_CYCLES (RELEASE_CYCLES),
        .CNT_W          (clock_ratio_pkg::CORE_RESET_CNT_W)
    ) u_release (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .core_reset_o (core_reset_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus request qualification; one request per ack
    assign req     = cyc_i && stb_i && !ack_o;
    assign wr_ctrl = req && we_i && adr_i == clock_ratio_pkg::CTRL_OFFSET;

    // Acknowledge one cycle after the strobe, every address answers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiplier: strapped while reset is held, then software owned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_multiplier_o <= strap_mult;
        end else if (wr_ctrl && sel_i[0]) begin
            pll_multiplier_o <= dat_i[clock_ratio_pkg::CTRL_MULT_LSB +: 6];
        end
    end

    // Divider code: reset forces divide by two regardless of history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_code <= clock_ratio_pkg::DIVCODE_RESET;
        end else if (wr_ctrl && sel_i[1]) begin
            div_code <= dat_i[clock_ratio_pkg::CTRL_DIV_LSB +: 2];
        end
    end

    // Input halver enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_halve_enable_o <= clock_ratio_pkg::HALVE_RESET;
        end else if (wr_ctrl && sel_i[1]) begin
            input_halve_enable_o <= dat_i[clock_ratio_pkg::CTRL_HALVE_BIT];
        end
    end

    // SDRAM ratio setting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdram_clock_ratio_o <= clock_ratio_pkg::SDR_RESET;
        end else if (wr_ctrl && sel_i[2]) begin
            sdram_clock_ratio_o <= dat_i[clock_ratio_pkg::CTRL_SDR_LSB +: 3];
        end
    end

    // Strap level seen while reset is held, kept for software to inspect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_pins <= ratio_select_pins_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency relations, all relative to the reference clock:
    // f_core = f_ref * vco_mult / core_div
    always_comb begin
        next_vco = {pll_multiplier_o, 1'b0};
        if (input_halve_enable_o) begin
            next_core_div = {post_div_value, 1'b0};
        end else begin
            next_core_div = {1'b0, post_div_value};
        end
    end

    // Registered ratio outputs, one cycle behind the control fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            post_divider_o <= clock_ratio_pkg::POST_DIV_MIN;
            vco_mult_o     <= '0;
            core_div_o     <= '0;
            periph_div_o   <= '0;
            sdram_div_o    <= '0;
        end else begin
            post_divider_o <= post_div_value;
            vco_mult_o     <= next_vco;
            core_div_o     <= next_core_div;
            periph_div_o   <= {next_core_div, 1'b0};
            sdram_div_o    <= 8'(next_core_div * sdram_clock_ratio_o);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets read as zero
    always_comb begin
        ctrl_word = '0;
        ctrl_word[clock_ratio_pkg::CTRL_MULT_LSB +: 6] = pll_multiplier_o;
        ctrl_word[clock_ratio_pkg::CTRL_DIV_LSB +: 2]  = div_code;
        ctrl_word[clock_ratio_pkg::CTRL_HALVE_BIT]     = input_halve_enable_o;
        ctrl_word[clock_ratio_pkg::CTRL_SDR_LSB +: 3]  = sdram_clock_ratio_o;
        if (adr_i == clock_ratio_pkg::CTRL_OFFSET) begin
            next_dat = ctrl_word;
        end else if (adr_i == clock_ratio_pkg::STATUS_OFFSET) begin
            next_dat = {27'h000_0000, post_divider_o[4:3] != 2'h0,
                        post_divider_o[2:1] != 2'h0, strap_pins, core_reset_o};
        end else if (adr_i == clock_ratio_pkg::RATIO_OFFSET) begin
            next_dat = {1'b0, periph_div_o, sdram_div_o,
                        2'h0, core_div_o, 1'b0, vco_mult_o};
        end else begin
            next_dat = 32'h0000_0000;
        end
    end

    // Read data is captured with the request and stands with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_o <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_strap_mult;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> pll_multiplier_o == $past(strap_mult);
    endproperty
    a_strap_mult: assert property (p_strap_mult)
        else $error("multiplier not taken from pins in reset");

    property p_div_set;
        @(posedge clk_i) disable iff (rst_i)
        post_divider_o inside {5'h02, 5'h04, 5'h08, 5'h10};
    endproperty
    a_div_set: assert property (p_div_set)
        else $error("post divider outside legal set");

    property p_div_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |=> post_divider_o == clock_ratio_pkg::POST_DIV_MIN;
    endproperty
    a_div_reset: assert property (p_div_reset)
        else $error("post divider not two after reset");

    // Attempts begun on the release edge see reset values one edge later
    property p_input_halve;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> core_div_o == ($past(input_halve_enable_o) ?
            6'(2 * $past(post_div_value)) : 6'($past(post_div_value)));
    endproperty
    a_input_halve: assert property (p_input_halve)
        else $error("core divisor ignores input halver");

    property p_vco;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> vco_mult_o == 7'(2 * $past(pll_multiplier_o));
    endproperty
    a_vco: assert property (p_vco)
        else $error("oscillator ratio not twice the multiplier");

    property p_periph;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> periph_div_o == 7'(2 * core_div_o);
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral period not two core periods");

    property p_sdram;
        @(posedge clk_i) disable iff (rst_i)
        ##1 sdram_div_o == 8'(core_div_o * $past(sdram_clock_ratio_o));
    endproperty
    a_sdram: assert property (p_sdram)
        else $error("sdram divisor wrong");

    property p_sw_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_ctrl && sel_i[0]) |=> pll_multiplier_o == $past(dat_i[5:0]) ##2
        vco_mult_o == 7'(2 * $past(pll_multiplier_o, 2));
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("software write did not reach the ratios");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held longer than one cycle");

    ////////////////////////////////////////////////////////////////////////
    // Reset values, then the sdram ratio write; the reset attempts start on
    // reset edges on purpose, so they carry no disable condition and look one edge back instead
    property p_strap_track;
        @(posedge clk_i)
        $past(rst_i) |-> pll_multiplier_o == $past(strap_mult);
    endproperty
    a_strap_track: assert property (p_strap_track)
        else $error("multiplier did not follow the pins in reset");

    property p_reset_div;
        @(posedge clk_i)
        $past(rst_i) |-> post_divider_o == clock_ratio_pkg::POST_DIV_MIN
                         && !input_halve_enable_o;
    endproperty
    a_reset_div: assert property (p_reset_div)
        else $error("reset did not force divide by two");

    property p_core_reset_hold;
        @(posedge clk_i)
        $past(rst_i) |-> core_reset_o;
    endproperty
    a_core_reset_hold: assert property (p_core_reset_hold)
        else $error("core reset low while reset held");

    property p_sdr_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_ctrl && sel_i[2]) |=> sdram_clock_ratio_o ==
            $past(dat_i[clock_ratio_pkg::CTRL_SDR_LSB +: 3]);
    endproperty
    a_sdr_write: assert property (p_sdr_write)
        else $error("sdram ratio write lost");

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake
    property p_ack_follows;
        @(posedge clk_i) disable iff (rst_i)
        req |=> ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows)
        else $error("request not acknowledged in one cycle");

    property p_ctrl_read;
        @(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i == clock_ratio_pkg::CTRL_OFFSET) |=>
            dat_o[clock_ratio_pkg::CTRL_MULT_LSB +: 6] ==
            $past(pll_multiplier_o);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read did not return the multiplier");

endmodule : pll_clock_ratio_ctrl

// [reset_driver_model.sv]
// Purpose: Board reset driver and ratio strap source facing the block
// Assumes: The reference clock comes from the bench and runs from time zero
// Notes:   Reset starts asserted at time zero and holds for HOLD cycles;
//          later pulses hold SETTLE cycles so clock and straps settle
`timescale 1ns/1ps
module reset_driver_model #(
    parameter int unsigned HOLD   = 20,
    parameter int unsigned SETTLE = 1000
) (
    input  wire logic       clk_i,
    input  wire logic       req_i,
    input  wire logic [1:0] pins_i,
    output logic            rst_o,
    output logic      [1:0] ratio_select_pins_o
);
    ////////////////////////////////////////////////////////////////////////
    // HOLD must stay at four or more, or pin defaults may not settle
    // SETTLE of 1000 cycles at 20 ns covers the 20 us strap setup; the
    // power-up pulse stays short to keep the run quick
    logic        rst_q    = 1'b1;
    logic [10:0] hold_cnt = 11'(HOLD);
    logic [1:0]  pins_q   = 2'b00;

    // Reset pulse; straps change only as a new pulse starts
    always @(posedge clk_i) begin
        if (req_i && !rst_q) begin
            rst_q    <= 1'b1;
            hold_cnt <= 11'(SETTLE);
            pins_q   <= pins_i;
        end else if (rst_q) begin
            if (hold_cnt <= 11'd1) begin
                rst_q <= 1'b0;
            end else begin
                hold_cnt <= hold_cnt - 11'd1;
            end
        end
    end

    // Straps stay put for the whole pulse, well ahead of release
    assign rst_o               = rst_q;
    assign ratio_select_pins_o = pins_q;
endmodule : reset_driver_model

// [tb_pll_clock_ratio_ctrl.sv]
// Purpose: Self-checking bench for the clock ratio and reset release block
// Assumes: Release count shortened to REL cycles for a quick run
// Notes:   Bus tasks hold every request until ack is sampled high
`timescale 1ns/1ps
module tb_pll_clock_ratio_ctrl;
    localparam int unsigned REL   = 10;
    localparam int unsigned LIMIT = 12000;
    localparam logic [5:0]  STRAP [4] = '{clock_ratio_pkg::STRAP_MULT_0,
        clock_ratio_pkg::STRAP_MULT_1, clock_ratio_pkg::STRAP_MULT_2,
        clock_ratio_pkg::STRAP_MULT_3};

    logic        clk_i;
    logic        rst;
    logic        rst_req;
    logic [1:0]  pins_req;
    logic [1:0]  pins;
    logic [3:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        we;
    logic [3:0]  sel;
    logic        cyc;
    logic        stb;
    logic        ack;
    logic        core_rst;
    logic [5:0]  mult;
    logic [4:0]  pdiv;
    logic        halve;
    logic [2:0]  sdr;
    logic [6:0]  vco;
    logic [5:0]  cdiv;
    logic [6:0]  pclk_div;
    logic [7:0]  sdiv;
    logic [5:0]  m;
    logic [2:0]  s;
    logic [4:0]  pd;
    logic [5:0]  cd;
    logic        h;
    logic [31:0] word;
    logic [31:0] q;
    int          n_errors;
    int          checks;
    int          cycle_count = 0;

    ////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    pll_clock_ratio_ctrl #(.RELEASE_CYCLES(REL)) dut (
        .clk_i(clk_i), .rst_i(rst), .adr_i(adr), .dat_i(wdat),
        .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
        .ack_o(ack), .ratio_select_pins_i(pins), .core_reset_o(core_rst),
        .pll_multiplier_o(mult), .post_divider_o(pdiv),
        .input_halve_enable_o(halve), .sdram_clock_ratio_o(sdr),
        .vco_mult_o(vco), .core_div_o(cdiv), .periph_div_o(pclk_div),
        .sdram_div_o(sdiv));

    reset_driver_model #(.HOLD(20)) driver (
        .clk_i(clk_i), .req_i(rst_req), .pins_i(pins_req), .rst_o(rst),
        .ratio_select_pins_o(pins));

    // 50 MHz reference clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    // Sample outputs once the edge's updates have landed
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick

    // One classic cycle; read data is taken at the ack edge only
    task automatic wb(input logic [3:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] se);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        adr  <= a;
        we   <= w;
        wdat <= d;
        sel  <= se;
        // No local limit: only the hang guard ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    // Wait out the reset pulse, then look at what reset left behind
    task automatic wait_release(input logic [1:0] p);
        int n;
        n = 0;
        do begin
            tick();
            n++;
        end while (rst === 1'b1 && n < 2000);
        chk(32'(mult), 32'(STRAP[p]));
        chk(32'(pdiv), 32'(clock_ratio_pkg::POST_DIV_MIN));
        chk(32'(sdr), 32'(clock_ratio_pkg::SDR_RESET));
        chk(32'(core_rst), 32'h0000_0001);
    endtask : wait_release

    task automatic reset_phase(input logic [1:0] p);
        @(posedge clk_i);
        rst_req  <= 1'b1;
        pins_req <= p;
        @(posedge clk_i);
        rst_req <= 1'b0;
        wait_release(p);
    endtask : reset_phase

    task automatic count_release;
        int n;
        n = 0;
        do begin
            tick();
            n++;
        end while (core_rst === 1'b1 && n < 100);
        chk(32'(n), 32'(REL));
    endtask : count_release

    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge clk_i) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == LIMIT) begin
            n_errors++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        rst_req  = 1'b0;
        pins_req = 2'b00;
        adr      = 4'h0;
        wdat     = 32'h0000_0000;
        we       = 1'b0;
        sel      = 4'h0;
        cyc      = 1'b0;
        stb      = 1'b0;
        n_errors = 0;
        checks   = 0;
        wait_release(2'b00);
        count_release();
        wb(clock_ratio_pkg::STATUS_OFFSET, 1'b0, 32'h0, 4'hF);
        chk(q & 32'h0000_0001, 32'h0000_0000);
        // Every divider code; multiplier kept under the oscillator limit
        for (int c = 0; c < 4; c++) begin
            h    = c[0];
            m    = h ? 6'(16 - c) : 6'(8 - c);
            s    = 3'(2 * c + 1);
            pd   = 5'(2 << c);
            cd   = h ? 6'(2 * pd) : 6'(pd);
            word = (32'(s) << 16) | (32'(h) << 12) | (32'(c) << 8) | 32'(m);
            wb(clock_ratio_pkg::CTRL_OFFSET, 1'b1, word, 4'hF);
            wb(clock_ratio_pkg::CTRL_OFFSET, 1'b0, 32'h0, 4'hF);
            chk(q, word);
            tick();
            chk(32'(pdiv), 32'(pd));
            chk(32'(halve), 32'(h));
            chk(32'(vco), 32'(m) * 2);
            chk(32'(cdiv), 32'(cd));
            chk(32'(pclk_div), 32'(cd) * 2);
            chk(32'(sdiv), (32'(cd) * 32'(s)) & 32'h0000_00FF);
            wb(clock_ratio_pkg::RATIO_OFFSET, 1'b0, 32'h0, 4'hF);
            chk(q, ((32'(cd) * 2) << 24)
                   | (((32'(cd) * 32'(s)) & 32'h0000_00FF) << 16)
                   | (32'(cd) << 8) | (32'(m) * 2));
        end
        // Single lane write touches the multiplier byte only
        wb(clock_ratio_pkg::CTRL_OFFSET, 1'b1, 32'hFFFF_FFFF, 4'h1);
        wb(clock_ratio_pkg::CTRL_OFFSET, 1'b0, 32'h0, 4'hF);
        chk(q, (word & 32'hFFFF_FFC0) | 32'h0000_003F);
        // Unmapped place reads zero and swallows writes
        wb(4'hC, 1'b1, 32'hFFFF_FFFF, 4'hF);
        wb(4'hC, 1'b0, 32'h0, 4'hF);
        chk(q, 32'h0000_0000);
        wb(clock_ratio_pkg::CTRL_OFFSET, 1'b0, 32'h0, 4'hF);
        chk(q, (word & 32'hFFFF_FFC0) | 32'h0000_003F);
        // Every strap code; one reset reasserted in mid-count
        for (int p = 0; p < 4; p++) begin
            reset_phase(2'(p));
            if (p == 2) begin
                repeat (3) tick();
                chk(32'(core_rst), 32'h0000_0001);
                reset_phase(2'(p));
            end
            count_release();
            wb(clock_ratio_pkg::STATUS_OFFSET, 1'b0, 32'h0, 4'hF);
            chk(q & 32'h0000_0007, 32'(p) << 1);
        end
        give_verdict();
    end
endmodule : tb_pll_clock_ratio_ctrl
